/* hdl/ppf_port_block.v */
// Operation
// - each pin except the port-thirteen pin picks port mode or its alternate function individually
// - port zero: four bidirectional pins, per-pin direction and pull-up
// - alt port-zero pin 0 feeds 16-bit timer clock and capture-a input
// - alt port-zero pin 1 is capture-b trigger or 16-bit timer output
// - port one: eight bidirectional pins, per-pin direction and pull-up
// - port one carries clocked serial in, out and two-way clock
// - port one carries two uarts; first only on larger variants
// - port one carries 8-bit timer clock in and three timer outputs
// - port-one interrupt input detects rising, falling or both edges
// - port two: four input-only pins, alternately analog inputs
// - port three: four bidirectional pins, per-pin direction and pull-up
// - alt port-three pins are edge-selectable interrupt inputs one to four
// - port twelve: one bidirectional pin, alternately interrupt input zero
// - port thirteen: one output-only pin, no alternate function
// - system reset input is active high
// - after reset all pins are inputs except the output-only pin
//
// Local design decisions: the strobed register port and the address map.
`timescale 1ns/100ps
`include "ppf_defs.vh"

module ppf_port_block #(
	parameter UART_A_PRESENT = 1
) (
	// clock and reset
	input wire clk_sys,
	input wire srst,
	// register port
	input wire [7:0] reg_addr,
	input wire [7:0] reg_wdata,
	input wire reg_wr,
	input wire reg_rd,
	output reg [7:0] reg_rdata,
	output wire irq,
	// external pins, oe low means driving
	input wire [3:0] port_zero_pins_i,
	output wire [3:0] port_zero_pins_o,
	output wire [3:0] port_zero_pins_oe_n,
	output wire [3:0] port_zero_pullup,
	input wire [7:0] port_one_pins_i,
	output wire [7:0] port_one_pins_o,
	output wire [7:0] port_one_pins_oe_n,
	output wire [7:0] port_one_pullup,
	input wire [3:0] port_two_pins_i,
	input wire [3:0] port_three_pins_i,
	output wire [3:0] port_three_pins_o,
	output wire [3:0] port_three_pins_oe_n,
	output wire [3:0] port_three_pullup,
	input wire port_twelve_pin_i,
	output wire port_twelve_pin_o,
	output wire port_twelve_pin_oe_n,
	output wire port_twelve_pullup,
	output wire port_thirteen_pin,
	// flash mode pins, inputs only; only pin a is sampled
	input wire flash_mode_pin_a,
	input wire flash_mode_pin_b,
	output wire flash_prog_mode,
	// 16-bit timer
	output wire timer16_clock_capture_in,
	output wire timer16_capture_in_b,
	input wire timer16_out,
	// clocked serial
	output wire sync_serial_data_in,
	input wire sync_serial_data_out,
	output wire sync_serial_clock_in,
	input wire sync_serial_clock_out,
	input wire sync_serial_clock_drive,
	// uarts
	output wire uart_a_receive,
	input wire uart_a_transmit,
	output wire uart_b_receive,
	input wire uart_b_transmit,
	// 8-bit timers
	output wire timer8_clock_in,
	input wire timer8_out,
	input wire aux_timer_a_out,
	input wire aux_timer_b_out,
	// analog
	output wire [3:0] analog_inputs,
	output wire [3:0] analog_sel,
	// external interrupt events, one-cycle pulses
	output wire ext_irq_zero,
	output wire [3:0] ext_irq_one_to_four,
	output wire ext_irq_five
);

	// =========================================================
	// registers
	reg [3:0] p0_out_q, p0_dir_q, p0_pu_q, p0_alt_q;
	reg [7:0] p1_out_q, p1_dir_q, p1_pu_q, p1_alt_q;
	reg [3:0] p2_alt_q;
	reg [3:0] p3_out_q, p3_dir_q, p3_pu_q, p3_alt_q;
	reg p12_out_q, p12_dir_q, p12_pu_q, p12_alt_q;
	reg p13_out_q;
	reg [1:0] cfg_q;
	reg [11:0] edge_q;
	reg [5:0] stat_q, mask_q;
	wire [5:0] irq_ev;

	// =========================================================
	// input synchronisers: three stages, change taken on agreement
	// flash mode pin b only matters to the programmer, so it is not sampled
	wire [21:0] raw_in = {flash_mode_pin_a,
		port_twelve_pin_i, port_three_pins_i, port_two_pins_i,
		port_one_pins_i, port_zero_pins_i};
	reg [21:0] s1_q, s2_q, s3_q, pin_q;
	always @(posedge clk_sys)
	begin
		if (srst)
		begin
			s1_q <= 22'h0;
			s2_q <= 22'h0;
			s3_q <= 22'h0;
			pin_q <= 22'h0;
		end
		else
		begin
			s1_q <= raw_in;
			s2_q <= s1_q;
			s3_q <= s2_q;
			pin_q <= (s2_q & s3_q) | (pin_q & (s2_q | s3_q));
		end
	end
	wire [3:0] p0_in = pin_q[3:0];
	wire [7:0] p1_in = pin_q[11:4];
	wire [3:0] p2_in = pin_q[15:12];
	wire [3:0] p3_in = pin_q[19:16];
	wire p12_in = pin_q[20];
	assign flash_prog_mode = pin_q[21];

	// =========================================================
	// register writes
	always @(posedge clk_sys)
	begin
		if (srst)
		begin
			p0_out_q <= 4'h0;
			p0_dir_q <= 4'hf;
			p0_pu_q <= 4'h0;
			p0_alt_q <= 4'h0;
			p1_out_q <= `PPF_ZERO_RST;
			p1_dir_q <= `PPF_DIR_RST;
			p1_pu_q <= `PPF_ZERO_RST;
			p1_alt_q <= `PPF_ZERO_RST;
			p2_alt_q <= 4'h0;
			p3_out_q <= 4'h0;
			p3_dir_q <= 4'hf;
			p3_pu_q <= 4'h0;
			p3_alt_q <= 4'h0;
			p12_out_q <= 1'b0;
			p12_dir_q <= 1'b1;
			p12_pu_q <= 1'b0;
			p12_alt_q <= 1'b0;
			p13_out_q <= 1'b0;
			cfg_q <= 2'h0;
			edge_q <= 12'h0;
			mask_q <= 6'h0;
		end
		else if (reg_wr)
		begin
			case (reg_addr)
			`PPF_A_P0_OUT: p0_out_q <= reg_wdata[3:0];
			`PPF_A_P0_DIR: p0_dir_q <= reg_wdata[3:0];
			`PPF_A_P0_PU: p0_pu_q <= reg_wdata[3:0];
			`PPF_A_P0_ALT: p0_alt_q <= reg_wdata[3:0];
			`PPF_A_P1_OUT: p1_out_q <= reg_wdata;
			`PPF_A_P1_DIR: p1_dir_q <= reg_wdata;
			`PPF_A_P1_PU: p1_pu_q <= reg_wdata;
			`PPF_A_P1_ALT: p1_alt_q <= reg_wdata;
			`PPF_A_P2_ALT: p2_alt_q <= reg_wdata[3:0];
			`PPF_A_P3_OUT: p3_out_q <= reg_wdata[3:0];
			`PPF_A_P3_DIR: p3_dir_q <= reg_wdata[3:0];
			`PPF_A_P3_PU: p3_pu_q <= reg_wdata[3:0];
			`PPF_A_P3_ALT: p3_alt_q <= reg_wdata[3:0];
			`PPF_A_P12_OUT: p12_out_q <= reg_wdata[0];
			`PPF_A_P12_DIR: p12_dir_q <= reg_wdata[0];
			`PPF_A_P12_PU: p12_pu_q <= reg_wdata[0];
			`PPF_A_P12_ALT: p12_alt_q <= reg_wdata[0];
			`PPF_A_P13_OUT: p13_out_q <= reg_wdata[0];
			`PPF_A_CFG: cfg_q <= reg_wdata[1:0];
			`PPF_A_EDGE_LO: edge_q[7:0] <= reg_wdata;
			`PPF_A_EDGE_HI: edge_q[11:8] <= reg_wdata[3:0];
			`PPF_A_IRQ_MASK: mask_q <= reg_wdata[5:0];
			default: ;
			endcase
		end
	end

	// status: set wins over write-one-to-clear
	wire [5:0] clr = (reg_wr && reg_addr == `PPF_A_IRQ_STAT) ?
		reg_wdata[5:0] : 6'h0;
	always @(posedge clk_sys)
	begin
		if (srst)
			stat_q <= 6'h0;
		else
			stat_q <= (stat_q & ~clr) | irq_ev;
	end
	assign irq = |(stat_q & mask_q);

	// =========================================================
	// output drivers
	// port 0: pin 1 drives timer16_out when alt and cfg selects output
	wire t16_out_sel = cfg_q[`PPF_CFG_T16_SEL];
	wire [3:0] p0_alt_drv = {2'b00, t16_out_sel, 1'b0} & p0_alt_q;
	wire [3:0] p0_oe = (~p0_dir_q & ~p0_alt_q) | p0_alt_drv;
	assign port_zero_pins_o = (p0_out_q & ~p0_alt_q) |
		({2'b00, timer16_out, 1'b0} & p0_alt_drv);
	assign port_zero_pins_oe_n = ~p0_oe;
	assign port_zero_pullup = p0_pu_q & p0_dir_q & ~p0_alt_q;

	// port 1 alternate sources: 0 sck/uart_a_transmit, 1 si/uart_a_receive, 2 so, 3 uart_b_transmit,
	// 4 uart_b_receive, 5 aux_timer_a_out, 6 aux_timer_b_out/int5, 7 timer8_clock_in/timer8_out
	wire uart_a_on = (UART_A_PRESENT != 0) && cfg_q[`PPF_CFG_UART_A_EN];
	wire [7:0] p1_alt_val = {timer8_out, aux_timer_b_out,
		aux_timer_a_out, 1'b0, uart_b_transmit, sync_serial_data_out,
		1'b0, uart_a_on ? uart_a_transmit : sync_serial_clock_out};
	// bit 7 drives timer8_out only when its direction bit says output
	wire [7:0] p1_alt_drv = {~p1_dir_q[7], ~p1_dir_q[6], 1'b1, 1'b0,
		1'b1, 1'b1, 1'b0, uart_a_on | sync_serial_clock_drive};
	wire [7:0] p1_oe = (~p1_dir_q & ~p1_alt_q) | (p1_alt_drv & p1_alt_q);
	assign port_one_pins_o = (p1_out_q & ~p1_alt_q) |
		(p1_alt_val & p1_alt_q);
	assign port_one_pins_oe_n = ~p1_oe;
	assign port_one_pullup = p1_pu_q & p1_dir_q & ~p1_alt_q;

	wire [3:0] p3_oe = ~p3_dir_q & ~p3_alt_q;
	assign port_three_pins_o = p3_out_q & ~p3_alt_q;
	assign port_three_pins_oe_n = ~p3_oe;
	assign port_three_pullup = p3_pu_q & p3_dir_q & ~p3_alt_q;

	wire p12_oe = ~p12_dir_q & ~p12_alt_q;
	assign port_twelve_pin_o = p12_out_q & ~p12_alt_q;
	assign port_twelve_pin_oe_n = ~p12_oe;
	assign port_twelve_pullup = p12_pu_q & p12_dir_q & ~p12_alt_q;
	assign port_thirteen_pin = p13_out_q;

	// =========================================================
	// peripheral inputs, idle low when pin not in alternate mode
	assign timer16_clock_capture_in = p0_in[0] & p0_alt_q[0];
	assign timer16_capture_in_b = p0_in[1] & p0_alt_q[1] &
		~t16_out_sel;
	assign sync_serial_clock_in = p1_in[0] & p1_alt_q[0] & ~uart_a_on;
	assign sync_serial_data_in = p1_in[1] & p1_alt_q[1] & ~uart_a_on;
	assign uart_a_receive = p1_in[1] & p1_alt_q[1] & uart_a_on;
	assign uart_b_receive = p1_in[4] & p1_alt_q[4];
	assign timer8_clock_in = p1_in[7] & p1_alt_q[7] & p1_dir_q[7];
	assign analog_sel = p2_alt_q;
	assign analog_inputs = p2_in & p2_alt_q;

	// =========================================================
	// edge detectors: 0 twelve, 1..4 port three, 5 port one bit 6
	wire [5:0] ei_lvl = {p1_in[6], p3_in, p12_in};
	wire [5:0] ei_en = {p1_alt_q[6] & p1_dir_q[6], p3_alt_q, p12_alt_q};
	reg [5:0] ei_prev_q;
	always @(posedge clk_sys)
	begin
		if (srst)
			ei_prev_q <= 6'h0;
		else
			ei_prev_q <= ei_lvl;
	end
	genvar g;
	generate
		for (g = 0; g < 6; g = g + 1)
		begin : g_edge
			wire rise = ei_lvl[g] & ~ei_prev_q[g];
			wire fall = ~ei_lvl[g] & ei_prev_q[g];
			assign irq_ev[g] = ei_en[g] &
				((rise & edge_q[2*g]) | (fall & edge_q[2*g+1]));
		end
	endgenerate
	assign ext_irq_zero = irq_ev[0];
	assign ext_irq_one_to_four = irq_ev[4:1];
	assign ext_irq_five = irq_ev[5];

	// =========================================================
	// register read, data one cycle after strobe
	always @(posedge clk_sys)
	begin
		if (srst)
			reg_rdata <= 8'h00;
		else if (reg_rd)
		begin
			case (reg_addr)
			`PPF_A_P0_OUT: reg_rdata <= {4'h0,
				(p0_in & p0_dir_q) | (p0_out_q & ~p0_dir_q)};
			`PPF_A_P0_DIR: reg_rdata <= {4'h0, p0_dir_q};
			`PPF_A_P0_PU: reg_rdata <= {4'h0, p0_pu_q};
			`PPF_A_P0_ALT: reg_rdata <= {4'h0, p0_alt_q};
			`PPF_A_P1_OUT: reg_rdata <= (p1_in & p1_dir_q) |
				(p1_out_q & ~p1_dir_q);
			`PPF_A_P1_DIR: reg_rdata <= p1_dir_q;
			`PPF_A_P1_PU: reg_rdata <= p1_pu_q;
			`PPF_A_P1_ALT: reg_rdata <= p1_alt_q;
			`PPF_A_P2_IN: reg_rdata <= {4'h0, p2_in};
			`PPF_A_P2_ALT: reg_rdata <= {4'h0, p2_alt_q};
			`PPF_A_P3_OUT: reg_rdata <= {4'h0,
				(p3_in & p3_dir_q) | (p3_out_q & ~p3_dir_q)};
			`PPF_A_P3_DIR: reg_rdata <= {4'h0, p3_dir_q};
			`PPF_A_P3_PU: reg_rdata <= {4'h0, p3_pu_q};
			`PPF_A_P3_ALT: reg_rdata <= {4'h0, p3_alt_q};
			`PPF_A_P12_OUT: reg_rdata <= {7'h0,
				p12_dir_q ? p12_in : p12_out_q};
			`PPF_A_P12_DIR: reg_rdata <= {7'h0, p12_dir_q};
			`PPF_A_P12_PU: reg_rdata <= {7'h0, p12_pu_q};
			`PPF_A_P12_ALT: reg_rdata <= {7'h0, p12_alt_q};
			`PPF_A_P13_OUT: reg_rdata <= {7'h0, p13_out_q};
			`PPF_A_CFG: reg_rdata <= {5'h0, flash_prog_mode, cfg_q};
			`PPF_A_EDGE_LO: reg_rdata <= edge_q[7:0];
			`PPF_A_EDGE_HI: reg_rdata <= {4'h0, edge_q[11:8]};
			`PPF_A_IRQ_STAT: reg_rdata <= {2'h0, stat_q};
			`PPF_A_IRQ_MASK: reg_rdata <= {2'h0, mask_q};
			default: reg_rdata <= 8'h00;
			endcase
		end
	end

endmodule // ppf_port_block

/* pkg/ppf_defs.vh */
`ifndef PPF_DEFS_VH
`define PPF_DEFS_VH

// register offsets (8-bit address, 8-bit data)
`define PPF_A_P0_OUT 8'h00
`define PPF_A_P0_DIR 8'h01
`define PPF_A_P0_PU 8'h02
`define PPF_A_P0_ALT 8'h03
`define PPF_A_P1_OUT 8'h04
`define PPF_A_P1_DIR 8'h05
`define PPF_A_P1_PU 8'h06
`define PPF_A_P1_ALT 8'h07
`define PPF_A_P2_IN 8'h08
`define PPF_A_P2_ALT 8'h09
`define PPF_A_P3_OUT 8'h0c
`define PPF_A_P3_DIR 8'h0d
`define PPF_A_P3_PU 8'h0e
`define PPF_A_P3_ALT 8'h0f
`define PPF_A_P12_OUT 8'h10
`define PPF_A_P12_DIR 8'h11
`define PPF_A_P12_PU 8'h12
`define PPF_A_P12_ALT 8'h13
`define PPF_A_P13_OUT 8'h14
`define PPF_A_CFG 8'h18
`define PPF_A_EDGE_LO 8'h19
`define PPF_A_EDGE_HI 8'h1a
`define PPF_A_IRQ_STAT 8'h1c
`define PPF_A_IRQ_MASK 8'h1d

// reset values
`define PPF_DIR_RST 8'hff
`define PPF_ZERO_RST 8'h00

// config field positions
`define PPF_CFG_T16_SEL 0
`define PPF_CFG_UART_A_EN 1

// edge select encoding per line
`define PPF_EDGE_NONE 2'h0
`define PPF_EDGE_RISE 2'h1
`define PPF_EDGE_FALL 2'h2
`define PPF_EDGE_BOTH 2'h3

`endif

/* tb/ppf_port_checker_assertions.sv */
`timescale 1ns/100ps

// ==========================================
// port block checker
module ppf_port_checker (
	// clock and reset
	input wire clk_sys,
	input wire srst,
	// register port
	input wire reg_rd,
	input wire [7:0] reg_rdata,
	input wire irq,
	// pins
	input wire [3:0] port_zero_pins_oe_n,
	input wire [3:0] port_zero_pullup,
	input wire [7:0] port_one_pins_oe_n,
	input wire [7:0] port_one_pullup,
	input wire [3:0] port_three_pins_oe_n,
	input wire [3:0] port_three_pullup,
	input wire port_twelve_pin_oe_n,
	input wire port_twelve_pullup,
	input wire port_thirteen_pin,
	input wire flash_mode_pin_a,
	input wire flash_prog_mode,
	// events and analog
	input wire ext_irq_zero,
	input wire [3:0] ext_irq_one_to_four,
	input wire ext_irq_five,
	input wire [3:0] analog_inputs,
	input wire [3:0] analog_sel
);
	default clocking cb @(posedge clk_sys);
	endclocking
	default disable iff (srst);

	property p_rst_dir;
		$fell(srst) |-> &{port_zero_pins_oe_n, port_one_pins_oe_n,
			port_three_pins_oe_n, port_twelve_pin_oe_n};
	endproperty
	a_rst_dir: assert property (p_rst_dir)
		else $error("pin not input after reset");
	property p_rst_quiet;
		$fell(srst) |-> !port_thirteen_pin && !irq && reg_rdata == 8'h00;
	endproperty
	a_rst_quiet: assert property (p_rst_quiet)
		else $error("outputs not cleared by reset");
	property p_pullup;
		({port_zero_pullup, port_one_pullup, port_three_pullup,
			port_twelve_pullup} & ~{port_zero_pins_oe_n, port_one_pins_oe_n,
			port_three_pins_oe_n, port_twelve_pin_oe_n}) == 17'h0;
	endproperty
	a_pullup: assert property (p_pullup)
		else $error("pull-up on a driven pin");
	property p_rdata_hold;
		!reg_rd |=> $stable(reg_rdata);
	endproperty
	a_rdata_hold: assert property (p_rdata_hold)
		else $error("read data moved without a read");
	property p_pulse0;
		ext_irq_zero |=> !ext_irq_zero;
	endproperty
	a_pulse0: assert property (p_pulse0)
		else $error("event zero pulse too long");
	property p_pulse4;
		|ext_irq_one_to_four |=>
			(ext_irq_one_to_four & $past(ext_irq_one_to_four)) == 4'h0;
	endproperty
	a_pulse4: assert property (p_pulse4)
		else $error("event one to four pulse too long");
	property p_pulse5;
		ext_irq_five |=> !ext_irq_five;
	endproperty
	a_pulse5: assert property (p_pulse5)
		else $error("event five pulse too long");
	property p_flash_hi;
		flash_mode_pin_a [*5] |-> flash_prog_mode;
	endproperty
	a_flash_hi: assert property (p_flash_hi)
		else $error("programming mode not seen");
	property p_flash_lo;
		!flash_mode_pin_a [*5] |-> !flash_prog_mode;
	endproperty
	a_flash_lo: assert property (p_flash_lo)
		else $error("programming mode while pin low");
	property p_analog;
		(analog_inputs & ~analog_sel) == 4'h0;
	endproperty
	a_analog: assert property (p_analog)
		else $error("analog input without alternate mode");

	c_event: cover property (ext_irq_zero);
	c_irq: cover property (irq ##1 !irq);
	c_prog: cover property (flash_prog_mode);
endmodule // ppf_port_checker

bind ppf_port_block ppf_port_checker i_ppf_port_checker (
	.clk_sys, .srst, .reg_rd, .reg_rdata, .irq, .port_zero_pins_oe_n,
	.port_zero_pullup, .port_one_pins_oe_n, .port_one_pullup,
	.port_three_pins_oe_n, .port_three_pullup, .port_twelve_pin_oe_n,
	.port_twelve_pullup, .port_thirteen_pin, .flash_mode_pin_a,
	.flash_prog_mode, .ext_irq_zero, .ext_irq_one_to_four, .ext_irq_five,
	.analog_inputs, .analog_sel
);

/* tb/ppf_pin_board.sv */
`timescale 1ns/100ps

// ==========================================
// board side of every pin
module ppf_pin_board #(
	parameter W = 21
) (
	// clock
	input wire clk_sys,
	// device side
	input wire [W-1:0] dev_o,
	input wire [W-1:0] dev_oe_n,
	input wire [W-1:0] dev_pu,
	// board side
	input wire [W-1:0] ext_v,
	input wire [W-1:0] ext_en,
	output wire [W-1:0] pin
);
	// a pin nobody holds toggles, so a stale level never reads as valid
	logic flt_q = 1'b0;
	always @(posedge clk_sys)
		flt_q <= ~flt_q;
	assign pin = (~dev_oe_n & dev_o) | (dev_oe_n & ext_en & ext_v)
		| (dev_oe_n & ~ext_en & (dev_pu | {W{flt_q}}));
endmodule // ppf_pin_board

/* tb/tb_top.sv */
`timescale 1ns/100ps
`include "ppf_defs.vh"

module tb_top;
	// ==========================================
	// signals
	logic clk_sys = 1'b0;
	logic srst = 1'b1;
	logic reg_wr = 1'b0;
	logic reg_rd = 1'b0;
	logic [7:0] reg_addr = 8'h00;
	logic [7:0] reg_wdata = 8'h00;
	logic [20:0] ext_v = '0;
	logic [20:0] ext_en = '0;
	logic [8:0] per = '0;
	logic flash_mode_pin_a = 1'b0;
	logic [3:0] n_zero = '0;
	logic [3:0] n_five = '0;
	int errors = 0;
	int checks = 0;
	int cyc = 0;
	wire [20:0] pin;
	wire [7:0] reg_rdata;
	wire irq, port_thirteen_pin, flash_prog_mode, ext_irq_zero, ext_irq_five;
	wire timer16_clock_capture_in, port_twelve_pin_o, port_twelve_pin_oe_n;
	wire port_twelve_pullup;
	wire [3:0] port_zero_pins_o, port_zero_pins_oe_n, port_zero_pullup;
	wire [3:0] port_three_pins_o, port_three_pins_oe_n, port_three_pullup;
	wire [7:0] port_one_pins_o, port_one_pins_oe_n, port_one_pullup;
	wire [3:0] ext_irq_one_to_four, analog_inputs, analog_sel;
	wire timer16_capture_in_b, sync_serial_data_in, sync_serial_clock_in;
	wire uart_a_receive, uart_b_receive, timer8_clock_in;
	// address, write data, read back
	logic [23:0] rows [12] = '{
		{`PPF_A_P0_DIR, 16'hff0f}, {`PPF_A_P0_PU, 16'h0a0a},
		{`PPF_A_P1_DIR, 16'h5a5a}, {`PPF_A_P1_PU, 16'hc3c3},
		{`PPF_A_P3_PU, 16'hff0f}, {`PPF_A_P12_DIR, 16'hfe00},
		{`PPF_A_P12_PU, 16'hff01}, {`PPF_A_P2_ALT, 16'hff0f},
		{`PPF_A_EDGE_HI, 16'hff0f}, {`PPF_A_IRQ_MASK, 16'hff3f},
		{`PPF_A_CFG, 16'hff03}, {8'h1f, 16'hff00}
	};

	ppf_port_block i_ppf_port_block (
		.clk_sys, .srst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
		.reg_rdata, .irq, .port_zero_pins_i(pin[3:0]),
		.port_zero_pins_o, .port_zero_pins_oe_n, .port_zero_pullup,
		.port_one_pins_i(pin[11:4]), .port_one_pins_o,
		.port_one_pins_oe_n, .port_one_pullup,
		.port_two_pins_i(pin[20:17]), .port_three_pins_i(pin[15:12]),
		.port_three_pins_o, .port_three_pins_oe_n, .port_three_pullup,
		.port_twelve_pin_i(pin[16]), .port_twelve_pin_o,
		.port_twelve_pin_oe_n, .port_twelve_pullup, .port_thirteen_pin,
		.flash_mode_pin_a, .flash_mode_pin_b(1'b0), .flash_prog_mode,
		.timer16_clock_capture_in, .timer16_capture_in_b,
		.timer16_out(per[0]), .sync_serial_data_in,
		.sync_serial_data_out(per[1]), .sync_serial_clock_in,
		.sync_serial_clock_out(per[2]), .sync_serial_clock_drive(per[3]),
		.uart_a_receive, .uart_a_transmit(per[4]), .uart_b_receive,
		.uart_b_transmit(per[5]), .timer8_clock_in, .timer8_out(per[6]),
		.aux_timer_a_out(per[7]), .aux_timer_b_out(per[8]),
		.analog_inputs, .analog_sel, .ext_irq_zero, .ext_irq_one_to_four,
		.ext_irq_five
	);

	ppf_pin_board #(.W(21)) i_ppf_pin_board (
		.clk_sys, .ext_v, .ext_en, .pin,
		.dev_o({4'h0, port_twelve_pin_o, port_three_pins_o,
			port_one_pins_o, port_zero_pins_o}),
		.dev_oe_n({4'hf, port_twelve_pin_oe_n, port_three_pins_oe_n,
			port_one_pins_oe_n, port_zero_pins_oe_n}),
		.dev_pu({4'h0, port_twelve_pullup, port_three_pullup,
			port_one_pullup, port_zero_pullup})
	);

	// ==========================================
	// clock, event counts, timeout
	always #10 clk_sys = ~clk_sys;
	always @(posedge clk_sys)
	begin
		n_zero <= n_zero + 4'(ext_irq_zero === 1'b1);
		n_five <= n_five + 4'(ext_irq_five === 1'b1);
		cyc <= cyc + 1;
		if (cyc == 3000)
		begin
			errors++;
			wrap_up();
		end
	end

	// ==========================================
	// tasks
	task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
		checks++;
		if (seen !== exp)
		begin
			errors++;
			$display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk_sys);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge clk_sys);
		reg_wr <= 1'b0;
	endtask
	task automatic rd(input logic [7:0] a, input logic [7:0] exp);
		@(posedge clk_sys);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge clk_sys);
		reg_rd <= 1'b0;
		#1 chk(reg_rdata, exp);
	endtask
	task automatic pins(input logic [20:0] v);
		@(posedge clk_sys);
		ext_v <= v;
		repeat (8) @(posedge clk_sys);
	endtask
	task automatic wrap_up();
		$display("errors=%0d checks=%0d", errors, checks);
		if (errors == 0 && checks > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask

	// ==========================================
	// main sequence
	initial
	begin
		repeat (10) @(posedge clk_sys);
		srst <= 1'b0;
		foreach (rows[i])
		begin
			wr(rows[i][23:16], rows[i][15:8]);
			rd(rows[i][23:16], rows[i][7:0]);
		end
		@(posedge clk_sys);
		srst <= 1'b1;
		repeat (10) @(posedge clk_sys);
		srst <= 1'b0;
		@(posedge clk_sys);
		#1 chk({port_zero_pins_oe_n, port_three_pins_oe_n}, 8'hff);
		chk(port_one_pins_oe_n, 8'hff);
		chk({port_twelve_pin_oe_n, port_thirteen_pin, irq}, 8'h04);
		chk({port_zero_pullup, port_three_pullup}, 8'h00);
		rd(`PPF_A_P1_DIR, 8'hff);
		// mixed directions on port zero
		@(posedge clk_sys);
		ext_en <= 21'h3;
		wr(`PPF_A_P0_DIR, 8'h03);
		wr(`PPF_A_P0_OUT, 8'h05);
		wr(`PPF_A_P0_PU, 8'h0f);
		pins(21'h2);
		rd(`PPF_A_P0_OUT, 8'h06);
		chk({port_zero_pins_oe_n, port_zero_pins_o[3:2]}, 8'h0d);
		chk(port_zero_pullup, 8'h03);
		wr(`PPF_A_P3_DIR, 8'h0a);
		wr(`PPF_A_P3_OUT, 8'h0f);
		wr(`PPF_A_P12_OUT, 8'h01);
		wr(`PPF_A_P12_DIR, 8'h00);
		#1 chk({port_three_pins_oe_n, port_three_pins_o}, 8'haf);
		chk({port_twelve_pin_oe_n, port_twelve_pin_o}, 8'h01);
		wr(`PPF_A_P3_OUT, 8'h00);
		// alternate routing on ports zero and two
		@(posedge clk_sys);
		ext_en <= 21'h1e0001;
		per <= 9'h001;
		wr(`PPF_A_CFG, 8'h01);
		wr(`PPF_A_P0_DIR, 8'h01);
		wr(`PPF_A_P0_ALT, 8'h03);
		wr(`PPF_A_P2_ALT, 8'h0f);
		pins(21'h140001);
		chk({timer16_clock_capture_in, port_zero_pins_o[1],
			port_zero_pullup[0]}, 8'h06);
		chk({analog_sel, analog_inputs}, 8'hfa);
		wr(`PPF_A_P13_OUT, 8'h01);
		#1 chk(port_thirteen_pin, 8'h01);
		// edge events: rise, rise, fall, both, none, both
		@(posedge clk_sys);
		ext_en <= '1;
		ext_v <= '0;
		wr(`PPF_A_P12_ALT, 8'h01);
		wr(`PPF_A_P3_ALT, 8'h0f);
		wr(`PPF_A_P1_ALT, 8'h40);
		wr(`PPF_A_EDGE_LO, 8'he5);
		wr(`PPF_A_EDGE_HI, 8'h0c);
		wr(`PPF_A_IRQ_MASK, 8'h3f);
		wr(`PPF_A_IRQ_STAT, 8'h3f);
		pins(21'h1f400);
		rd(`PPF_A_IRQ_STAT, 8'h2b);
		pins(21'h0);
		rd(`PPF_A_IRQ_STAT, 8'h2f);
		chk({n_zero, n_five}, 8'h12);
		chk(irq, 8'h01);
		wr(`PPF_A_IRQ_MASK, 8'h00);
		#1 chk(irq, 8'h00);
		wr(`PPF_A_IRQ_STAT, 8'h3f);
		rd(`PPF_A_IRQ_STAT, 8'h00);
		// port one alternate routing, then uart a and capture b
		wr(`PPF_A_P1_DIR, 8'h3f);
		wr(`PPF_A_P1_ALT, 8'hff);
		per <= 9'h1c7;
		pins(21'h132);
		chk(port_one_pins_o & ~port_one_pins_oe_n, 8'he4);
		chk({sync_serial_clock_in, sync_serial_data_in, uart_a_receive,
			uart_b_receive, timer8_clock_in}, 8'h1a);
		wr(`PPF_A_CFG, 8'h02);
		#1 chk({timer16_capture_in_b, sync_serial_clock_in,
			sync_serial_data_in, uart_a_receive, port_one_pins_oe_n[0]},
			8'h12);
		@(posedge clk_sys);
		flash_mode_pin_a <= 1'b1;
		repeat (8) @(posedge clk_sys);
		rd(`PPF_A_CFG, 8'h06);
		wrap_up();
	end
endmodule // tb_top
